// file: ibo_pkg.sv
// Constants and types shared by the isolated bitstream output block
package ibo_pkg;
  // ==========================================
  // Data path widths
  localparam int IBO_IN_W = 16;
  localparam int IBO_INT_W = 24;
  localparam int IBO_FIFO_DEPTH = 8;
  localparam int IBO_MARK_W = 7;
  // ==========================================
  // Clipping level in millivolts, 1.25 V
  localparam logic signed [15:0] IBO_VCLIP_MV = 16'h04E2;
  // Integrator saturation bound
  localparam logic signed [23:0] IBO_INT_LIM = 24'h00_8000;
  // Marker slot inside a 128-bit clipped run
  localparam logic [6:0] IBO_MARK_SLOT = 7'h7F;
  localparam logic [6:0] IBO_MARK_RST = 7'h00;
  // ==========================================
  // Reset values
  localparam logic IBO_DOUT_RST = 1'b0;
  localparam logic [2:0] IBO_SYNC_RST = 3'h0;
  // ==========================================
  // Output modes, Gray coded along nosupply, run, clip
  typedef enum logic [1:0] {
    IBO_NOSUP = 2'b00,
    IBO_RUN = 2'b01,
    IBO_CLIP = 2'b11
  } ibo_mode_e;
endpackage

// file: ibo_bitstream.sv
// Isolated bitstream output: sample FIFO, second order modulator, clip marker, fail-safe
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Sample FIFO
module ibo_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      in_ready <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      in_ready <= (nxt_cnt != FULL_CNT);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
  property p_full_blocks;
    @(posedge ref_clk) disable iff (!nrst) (cnt_ff == FULL_CNT) |-> !in_ready;
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("fifo ready while full");
endmodule

// ==========================================
// Top level
module ibo_bitstream
  import ibo_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins from the far side and the high side
  input wire logic conversion_clock_in,
  input wire logic high_side_supply,
  // Differential input samples in millivolts, signed
  input wire logic in_valid,
  input wire logic [IBO_IN_W-1:0] in_data,
  output logic in_ready,
  // Modulator bitstream
  output logic bitstream_out
);
  // ==========================================
  // Pin synchronisers
  logic [2:0] clk_sync_ff;
  logic [2:0] sup_sync_ff;
  logic clk_lvl_ff;
  logic supply_ok_ff;
  logic conv_tick_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_sync_ff <= IBO_SYNC_RST;
      sup_sync_ff <= IBO_SYNC_RST;
    end else begin
      clk_sync_ff <= {clk_sync_ff[1:0], conversion_clock_in};
      sup_sync_ff <= {sup_sync_ff[1:0], high_side_supply};
    end
  end
  // Accepted levels change only once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_lvl_ff <= 1'b0;
      supply_ok_ff <= 1'b0;
      conv_tick_ff <= 1'b0;
    end else begin
      conv_tick_ff <= 1'b0;
      if (clk_sync_ff[1] == clk_sync_ff[2]) begin
        clk_lvl_ff <= clk_sync_ff[2];
        conv_tick_ff <= clk_sync_ff[2] && !clk_lvl_ff;
      end
      if (sup_sync_ff[1] == sup_sync_ff[2]) begin
        supply_ok_ff <= sup_sync_ff[2];
      end
    end
  end
  // ==========================================
  // Sample buffer, drained one word per conversion edge
  logic fifo_valid;
  logic [IBO_IN_W-1:0] fifo_data;
  logic signed [IBO_IN_W-1:0] vin_ff;
  ibo_fifo #(
    .WIDTH(IBO_IN_W),
    .DEPTH(IBO_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(conv_tick_ff)
  );
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vin_ff <= '0;
    end else if (conv_tick_ff && fifo_valid) begin
      vin_ff <= signed'(fifo_data);
    end
  end

  // ==========================================
  // Mode selection
  ibo_mode_e mode_ff;
  ibo_mode_e nxt_mode;
  logic clip_neg_ff;
  logic in_over;
  logic in_under;
  assign in_over = (vin_ff >= IBO_VCLIP_MV);
  assign in_under = (vin_ff <= -IBO_VCLIP_MV);
  always_comb begin
    case (mode_ff)
      IBO_NOSUP,
      IBO_RUN,
      IBO_CLIP: begin
        if (!supply_ok_ff) begin
          nxt_mode = IBO_NOSUP;
        end else if (in_over || in_under) begin
          nxt_mode = IBO_CLIP;
        end else begin
          nxt_mode = IBO_RUN;
        end
      end
      default: begin
        nxt_mode = IBO_NOSUP;
      end
    endcase
  end
  // Mode advances only on conversion edges, so a paused clock freezes mode, integrators, marker count and output bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= IBO_NOSUP;
      clip_neg_ff <= 1'b0;
    end else if (conv_tick_ff) begin
      mode_ff <= nxt_mode;
      clip_neg_ff <= in_under;
    end
  end
  // ==========================================
  // Second order modulator, feedback is +/- the clipping level
  logic signed [IBO_INT_W-1:0] int1_ff;
  logic signed [IBO_INT_W-1:0] int2_ff;
  logic signed [IBO_INT_W-1:0] nxt_int1;
  logic signed [IBO_INT_W-1:0] nxt_int2;
  logic signed [IBO_INT_W-1:0] vin_ext;
  logic signed [IBO_INT_W-1:0] fb;
  function automatic logic signed [IBO_INT_W-1:0] sat(input logic signed [IBO_INT_W:0] v);
    logic signed [IBO_INT_W:0] lim;
    lim = {IBO_INT_LIM[IBO_INT_W-1], IBO_INT_LIM};
    if (v > lim) begin
      sat = IBO_INT_LIM;
    end else if (v < -lim) begin
      sat = -IBO_INT_LIM;
    end else begin
      sat = v[IBO_INT_W-1:0];
    end
  endfunction
  // One volt against 1.25 V clipping gives 90 % ones, minus one volt 10 %
  assign vin_ext = IBO_INT_W'(vin_ff);
  assign fb = bitstream_out ? IBO_INT_W'(IBO_VCLIP_MV) : -IBO_INT_W'(IBO_VCLIP_MV);
  assign nxt_int1 = sat((IBO_INT_W+1)'(int1_ff) + (IBO_INT_W+1)'(vin_ext) - (IBO_INT_W+1)'(fb));
  assign nxt_int2 = sat((IBO_INT_W+1)'(int2_ff) + (IBO_INT_W+1)'(nxt_int1)
                        - (IBO_INT_W+1)'(fb));
  // Integrators cleared outside the linear mode so a recovery starts balanced
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int1_ff <= '0;
      int2_ff <= '0;
    end else if (conv_tick_ff) begin
      if (nxt_mode == IBO_RUN) begin
        int1_ff <= nxt_int1;
        int2_ff <= nxt_int2;
      end else begin
        int1_ff <= '0;
        int2_ff <= '0;
      end
    end
  end
  // ==========================================
  // Clip marker counter
  logic [IBO_MARK_W-1:0] mark_cnt_ff;
  logic mark_now;
  assign mark_now = (mark_cnt_ff == IBO_MARK_SLOT);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mark_cnt_ff <= IBO_MARK_RST;
    end else if (conv_tick_ff) begin
      if (nxt_mode != IBO_CLIP || mode_ff != IBO_CLIP || clip_neg_ff != in_under) begin
        mark_cnt_ff <= IBO_MARK_RST;
      end else begin
        mark_cnt_ff <= mark_cnt_ff + 1'b1;
      end
    end
  end

  // ==========================================
  // Output bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bitstream_out <= IBO_DOUT_RST;
    end else if (conv_tick_ff) begin
      case (nxt_mode)
        IBO_NOSUP: begin
          bitstream_out <= 1'b0;
        end
        IBO_CLIP: begin
          if (mode_ff == IBO_CLIP && clip_neg_ff == in_under && mark_now) begin
            bitstream_out <= in_under;
          end else begin
            bitstream_out <= !in_under;
          end
        end
        default: begin
          bitstream_out <= (nxt_int2 >= 0);
        end
      endcase
    end
  end
  // ==========================================
  // Checks
  property p_change_on_edge;
    @(posedge ref_clk) disable iff (!nrst) $changed(bitstream_out) |-> $past(conv_tick_ff);
  endproperty
  a_change_on_edge: assert property (p_change_on_edge) else $error("output moved off edge");
  property p_failsafe;
    @(posedge ref_clk) disable iff (!nrst) (conv_tick_ff && !supply_ok_ff) |=> !bitstream_out;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("no supply but output high");
  property p_marker_neg;
    @(posedge ref_clk) disable iff (!nrst)
      (conv_tick_ff && supply_ok_ff && mode_ff == IBO_CLIP && clip_neg_ff && in_under && mark_now)
      |=> bitstream_out;
  endproperty
  a_marker_neg: assert property (p_marker_neg) else $error("missing low-clip marker");
  property p_clip_low;
    @(posedge ref_clk) disable iff (!nrst)
      (conv_tick_ff && supply_ok_ff && in_under && !(mode_ff == IBO_CLIP && clip_neg_ff && mark_now))
      |=> !bitstream_out;
  endproperty
  a_clip_low: assert property (p_clip_low) else $error("low clip not zero");
  property p_clip_high;
    @(posedge ref_clk) disable iff (!nrst)
      (conv_tick_ff && supply_ok_ff && in_over && !(mode_ff == IBO_CLIP && !clip_neg_ff && mark_now))
      |=> bitstream_out;
  endproperty
  a_clip_high: assert property (p_clip_high) else $error("high clip not one");
  property p_marker_single;
    @(posedge ref_clk) disable iff (!nrst)
      (conv_tick_ff && mode_ff == IBO_CLIP && nxt_mode == IBO_CLIP && mark_now)
      |=> (mark_cnt_ff == IBO_MARK_RST);
  endproperty
  a_marker_single: assert property (p_marker_single) else $error("marker not one slot");
  property p_int_bounded;
    @(posedge ref_clk) disable iff (!nrst)
      (int2_ff <= IBO_INT_LIM) && (int2_ff >= -IBO_INT_LIM) && (mode_ff != IBO_RUN ? int1_ff == 0 : 1'b1);
  endproperty
  a_int_bounded: assert property (p_int_bounded) else $error("integrator out of range");
  property p_freeze;
    @(posedge ref_clk) disable iff (!nrst)
      !conv_tick_ff |=> $stable(mode_ff) && $stable(mark_cnt_ff) && $stable(int2_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved without clock");
endmodule
`default_nettype wire

// file: ibo_sinc_rx.sv
// Far-side receiver model: conversion clock source, bit capture, sinc3 decimator
`timescale 1ns/1ps
`default_nettype none
module ibo_sinc_rx (
  // Control
  input wire logic ref_clk,
  input wire logic run,
  // Link
  output logic conv_clk,
  input wire logic bitstream,
  // Results
  output logic rx_bit,
  output logic rx_stb,
  output logic [15:0] word,
  output logic [15:0] word_cnt
);
  logic [1:0] ph_ff = 2'h0;
  logic [7:0] n_ff = 8'h00;
  logic [24:0] i1 = '0, i2 = '0, i3 = '0, c1 = '0, c2 = '0, c3 = '0;
  logic [24:0] d1;
  logic [24:0] d2;
  logic [24:0] d3;
  logic bit_ff = 1'b0;
  logic stb_ff = 1'b0;
  logic [15:0] word_ff = 16'h0000;
  logic [15:0] cnt_ff = 16'h0000;
  assign rx_bit = bit_ff;
  assign rx_stb = stb_ff;
  assign word = word_ff;
  assign word_cnt = cnt_ff;
  // Two ref cycles high, two low: 5 MHz; parks low when stopped
  assign conv_clk = ph_ff[1];
  // Comb stages work on the values held at the decimation edge
  assign d1 = i3 - c1;
  assign d2 = d1 - c2;
  assign d3 = d2 - c3;
  always @(posedge ref_clk) begin
    stb_ff <= 1'b0;
    if (run || ph_ff != 2'h0) begin
      ph_ff <= ph_ff + 2'h1;
      if (ph_ff == 2'h1) begin
        // Capture at the rising conversion edge
        bit_ff <= bitstream;
        stb_ff <= 1'b1;
        i1 <= i1 + {24'h00_0000, bitstream};
        i2 <= i2 + i1;
        i3 <= i3 + i2;
        n_ff <= n_ff + 8'h01;
        if (n_ff == 8'hFF) begin
          // Ratio 256, bits 23:8 of the 25-bit result, saturated to FFFF when bit 24 is set
          c1 <= i3;
          c2 <= d1;
          c3 <= d2;
          word_ff <= d3[24] ? 16'hFFFF : d3[23:8];
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_ibo_bitstream.sv
// Self-checking testbench of the isolated bitstream output block
`timescale 1ns/1ps
`default_nettype none
module tb_ibo_bitstream;
  import ibo_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b0;
  logic supply = 1'b0;
  logic in_valid = 1'b0;
  logic [IBO_IN_W-1:0] in_data = 16'h0000;
  wire logic in_ready, bitstream_out, conv_clk, rx_bit, rx_stb;
  wire logic [15:0] word, word_cnt;
  int miscompares = 0;
  int n_compared = 0;
  int ones, marks, bad;

  always #25 ref_clk = ~ref_clk;

  ibo_bitstream u_dut (.ref_clk(ref_clk), .nrst(nrst), .conversion_clock_in(conv_clk),
    .high_side_supply(supply), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .bitstream_out(bitstream_out));
  ibo_sinc_rx u_rx (.ref_clk(ref_clk), .run(run), .conv_clk(conv_clk),
    .bitstream(bitstream_out), .rx_bit(rx_bit), .rx_stb(rx_stb), .word(word),
    .word_cnt(word_cnt));

  // ==========================================
  // Helpers
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic fail;
    miscompares++;
    $display("BAD t=%0t wait bound used up got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic push(input logic [15:0] v);
    int k;
    in_valid = 1'b1;
    in_data = v;
    for (k = 0; k < 100 && in_ready !== 1'b1; k++) cyc(1);
    if (k == 100) fail();
    cyc(1);
    in_valid = 1'b0;
  endtask
  // Collect n captured bits; count ones and bits unlike lvl with their spacing
  task automatic bits(input int n, input logic lvl);
    int t;
    int last;
    ones = 0;
    marks = 0;
    bad = 0;
    last = -1;
    for (int i = 0; i < n; i++) begin
      for (t = 0; t < 20 && rx_stb !== 1'b1; t++) cyc(1);
      if (t == 20) fail();
      ones += int'(rx_bit);
      if (rx_bit !== lvl) begin
        if (last >= 0 && i - last != 128) bad++;
        last = i;
        marks++;
      end
      cyc(1);
    end
  endtask
  task automatic sinc(input logic [15:0] v, input logic [15:0] exp);
    int k;
    logic [15:0] w0;
    logic [15:0] d;
    push(v);
    w0 = word_cnt;
    for (k = 0; k < 6000 && word_cnt !== w0 + 16'h0004; k++) cyc(1);
    if (k == 6000) fail();
    d = (word > exp) ? word - exp : exp - word;
    check((d <= 16'h00C8) ? exp : word, exp);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_fifo;
    int acc;
    acc = 0;
    in_valid = 1'b1;
    for (int k = 0; k < 20; k++) begin
      if (in_ready === 1'b1) acc++;
      cyc(1);
    end
    in_valid = 1'b0;
    check(acc, 8);
    run = 1'b1;
    bits(40, 1'b0);
    check(in_ready, 1'b1);
  endtask
  task automatic t_clip(input logic lvl);
    push(lvl ? IBO_VCLIP_MV : -IBO_VCLIP_MV);
    bits(64, lvl);
    bits(384, lvl);
    check(marks, 3);
    check(bad, 0);
    check(ones, lvl ? 381 : 3);
  endtask
  task automatic t_nosupply;
    supply = 1'b0;
    push(IBO_VCLIP_MV);
    bits(16, 1'b0);
    bits(256, 1'b0);
    check(ones, 0);
    check(marks, 0);
    supply = 1'b1;
  endtask
  task automatic t_pause;
    int chg;
    logic b;
    chg = 0;
    push(16'h0000);
    bits(32, 1'b0);
    run = 1'b0;
    cyc(10);
    b = bitstream_out;
    for (int k = 0; k < 60; k++) begin
      if (bitstream_out !== b || rx_stb !== 1'b0) chg++;
      cyc(1);
    end
    check(chg, 0);
    run = 1'b1;
    bits(16, 1'b0);
    check(ones > 0 && ones < 16, 1'b1);
  endtask

  initial begin
    cyc(10);
    check(in_ready, 1'b0);
    check(bitstream_out, IBO_DOUT_RST);
    cyc(10);
    nrst = 1'b1;
    supply = 1'b1;
    cyc(5);
    t_fifo();
    sinc(16'h0000, 16'h8000);
    sinc(16'h03E8, 16'hE666);
    sinc(16'hFC18, 16'h1999);
    sinc(16'h0271, 16'hC000);
    t_clip(1'b1);
    t_clip(1'b0);
    t_nosupply();
    t_pause();
    test_done();
  end
endmodule
`default_nettype wire
